// file: fpc_pkg.sv
// Package of constants and types for the front panel control block
package fpc_pkg;
	localparam int          CLK_PERIOD_NS   = 8;      // System clock period
	localparam int          LOAD_HOLD_NS    = 200;    // Examine hold-off after address load
	localparam int          LOAD_HOLD_CYC   = (LOAD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_W          = 14;     // Panel address width
	localparam int          DATA_W          = 8;      // Processor data width
	localparam logic [7:0]  JUMP_OPCODE_DEF = 8'h44;  // Default jump pattern, overridable
	localparam logic [7:0]  HALT_OPCODE_DEF = 8'hff;  // Default halt pattern, overridable
	localparam logic [1:0]  SEL_JUMP        = 2'h1;   // Select counter: jump opcode byte
	localparam logic [1:0]  SEL_LOW         = 2'h2;   // Select counter: low address byte
	localparam logic [1:0]  SEL_HIGH        = 2'h3;   // Select counter: high address byte
	localparam logic [1:0]  SEL_HALT        = 2'h0;   // Select counter: halt opcode
	localparam logic [1:0]  TS_FIRST        = 2'h1;   // Decoded time state codes
	localparam logic [1:0]  TS_SECOND       = 2'h2;
	localparam logic [1:0]  TS_THIRD        = 2'h3;

	// Examine sequencer states
	typedef enum logic [4:0] {
		EX_IDLE  = 5'b00001,
		EX_HOLD  = 5'b00010,
		EX_READ  = 5'b00100,
		EX_PH1   = 5'b01000,
		EX_PH2   = 5'b10000
	} fpc_ex_state_t;

	// Address load sequencer states
	typedef enum logic [2:0] {
		LD_IDLE = 3'b001,
		LD_LOW  = 3'b010,
		LD_HIGH = 3'b100
	} fpc_ld_state_t;
endpackage : fpc_pkg

// file: fpc_load_if.sv
// Interface carrying address-load requests and strobes between panel modules
`timescale 1ns/1ps
`default_nettype none
interface fpc_load_if;
	logic       start;     // One-cycle request to run an address load
	logic       busy;      // Load sequence in progress
	logic       done;      // One-cycle pulse when load ends
	logic       low_strb;  // Low byte strobe towards processor
	logic       high_strb; // High byte strobe towards processor
	logic       sel_high;  // Output bus carries the high address byte

	modport seq (input start, output busy, done, low_strb, high_strb, sel_high);
	modport ctl (output start, input busy, done, low_strb, high_strb, sel_high);
endinterface : fpc_load_if
`default_nettype wire

// file: fpc_load_seq.sv
// Address load sequencer: low strobe, high strobe, then a hold-off
`timescale 1ns/1ps
`default_nettype none
module fpc_load_seq
	import fpc_pkg::*;
#(
	parameter int HOLD_CYC = LOAD_HOLD_CYC
) (
	input  wire logic  clk,
	input  wire logic  rst,
	fpc_load_if.seq    ld
);
	fpc_ld_state_t state_reg;  // Current phase
	fpc_ld_state_t state_next; // Next phase
	logic [7:0]    hold_reg;   // Hold-off countdown after the high strobe
	logic [7:0]    hold_next;
	logic          done_reg;   // End-of-sequence pulse

	// Next-state decode: two strobes one cycle each, then the hold-off
	always_comb begin
		state_next = state_reg;
		hold_next  = (hold_reg != 8'h00) ? hold_reg - 8'h01 : 8'h00;
		unique case (state_reg)
			LD_IDLE: begin
				if (ld.start) begin
					state_next = LD_LOW;
				end
			end
			LD_LOW: begin
				state_next = LD_HIGH;
			end
			LD_HIGH: begin
				state_next = LD_IDLE;
				hold_next  = 8'(HOLD_CYC);
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= LD_IDLE;
			hold_reg  <= 8'h00;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			hold_reg  <= hold_next;
			done_reg  <= (hold_reg == 8'h01);
		end
	end

	// Bus holds busy through the hold-off so the read waits for the new address
	assign ld.busy      = (state_reg != LD_IDLE) || (hold_reg != 8'h00);
	assign ld.done      = done_reg;
	assign ld.low_strb  = (state_reg == LD_LOW);
	assign ld.high_strb = (state_reg == LD_HIGH);
	assign ld.sel_high  = (state_reg == LD_HIGH);
endmodule : fpc_load_seq
`default_nettype wire

// file: fpc_run_ctl.sv
// Start and halt jamming control: select counter and opcode multiplexer
`timescale 1ns/1ps
`default_nettype none
module fpc_run_ctl
	import fpc_pkg::*;
#(
	parameter logic [7:0] JUMP_OPCODE = JUMP_OPCODE_DEF,
	parameter logic [7:0] HALT_OPCODE = HALT_OPCODE_DEF
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             start_press,  // Start button pulse
	input  wire logic             stop_level,   // Stop switch position
	input  wire logic             ack_flag,     // Interrupt acknowledge third state
	input  wire logic             third_pulse,  // Third time state entry pulse
	input  wire logic             halt_exec,    // Halt opcode fetched and executed
	input  wire logic [ADDR_W-1:0] addr,        // Switch register address
	output logic                  start_ff,
	output logic                  halt_ff,
	output logic                  inject,
	output logic [DATA_W-1:0]     inject_byte,
	output logic                  mem_block
);
	logic [1:0] sel_reg;    // Two-bit multiplexer select counter
	logic       inject_reg; // Jam enable
	logic       block_reg;  // Memory disable during jump jamming
	logic       stop_d_reg; // Previous stop level for the actuation edge
	// A held stop switch must not interrupt again once the halt has cleared the flop
	wire        stop_rise = stop_level && !stop_d_reg;

	// Opcode multiplexer selected by the counter
	assign inject_byte = (sel_reg == SEL_JUMP) ? JUMP_OPCODE :
	                     (sel_reg == SEL_LOW)  ? addr[7:0] :
	                     (sel_reg == SEL_HIGH) ? {2'b11, addr[13:8]} : HALT_OPCODE;
	assign inject    = inject_reg;
	assign mem_block = block_reg;

	// Start and halt sequencing, counter steps on each third state of a jump jam
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_ff   <= 1'b0;
			halt_ff    <= 1'b0;
			sel_reg    <= SEL_HALT;
			inject_reg <= 1'b0;
			block_reg  <= 1'b0;
			stop_d_reg <= 1'b0;
		end else if (halt_exec) begin
			start_ff   <= 1'b0;
			halt_ff    <= stop_rise;
			stop_d_reg <= stop_level;
			sel_reg    <= SEL_HALT;
			inject_reg <= 1'b0;
			block_reg  <= 1'b0;
		end else begin
			if (start_press && !stop_level && !halt_ff) begin
				start_ff <= 1'b1;
			end
			stop_d_reg <= stop_level;
			if (stop_rise) begin
				halt_ff <= 1'b1;
			end
			if (ack_flag && halt_ff) begin
				sel_reg    <= SEL_HALT;
				inject_reg <= 1'b1;
			end else if (ack_flag && start_ff) begin
				sel_reg    <= SEL_JUMP;
				inject_reg <= 1'b1;
				block_reg  <= 1'b1;
			end else if (third_pulse && inject_reg && !halt_ff) begin
				if (sel_reg == SEL_HIGH) begin
					// Jump fully fetched: release memories and leave the jam
					sel_reg    <= SEL_HALT;
					inject_reg <= 1'b0;
					block_reg  <= 1'b0;
					start_ff   <= 1'b0;
				end else begin
					sel_reg <= sel_reg + 2'h1;
				end
			end
		end
	end
endmodule : fpc_run_ctl
`default_nettype wire

// file: fpc_front_panel.sv
// Front panel control top: examine, stepping, start and halt towards the processor
`timescale 1ns/1ps
`default_nettype none
module fpc_front_panel
	import fpc_pkg::*;
#(
	parameter logic [7:0] JUMP_OPCODE = JUMP_OPCODE_DEF,
	parameter logic [7:0] HALT_OPCODE = HALT_OPCODE_DEF,
	parameter int         HOLD_CYC    = LOAD_HOLD_CYC
) (
	input  wire logic                      SYS_CLK,
	input  wire logic                      SYS_RST,
	input  wire logic                      EXAMINE_SWITCH,
	input  wire logic                      LOAD_SWITCH,
	input  wire logic                      SHOW_ADDRESS_BUTTON,
	input  wire logic                      SHOW_DATA_BUTTON,
	input  wire logic                      STEP_MODE_SWITCH,
	input  wire logic                      RESUME_SWITCH,
	input  wire logic                      RUN_FROM_ADDRESS_SWITCH,
	input  wire logic                      STOP_SWITCH,
	input  wire logic [fpc_pkg::ADDR_W-1:0] SWITCH_REG,
	input  wire logic [1:0]                TIME_STATE,
	input  wire logic                      INTERRUPT_ACK_STATE_FLAG,
	input  wire logic                      HALT_EXECUTED,
	input  wire logic                      COMMAND_CYCLE_TYPE,
	input  wire logic                      READ_CYCLE_TYPE,
	input  wire logic                      WRITE_CYCLE_TYPE,
	input  wire logic                      FETCH_CYCLE_TYPE,
	input  wire logic                      WAITING,
	input  wire logic [fpc_pkg::ADDR_W-1:0] PROC_ADDR,
	input  wire logic [fpc_pkg::DATA_W-1:0] DATA_IN,
	output logic      [fpc_pkg::DATA_W-1:0] DATA_OUT,
	output logic                           DATA_OE,
	output logic                           FORCED_MEMORY_READ,
	output logic                           FORCED_INPUT_GATE,
	output logic                           FORCED_INTERRUPT,
	output logic                           OPCODE_INJECT_ENABLE,
	output logic                           LOW_BYTE_STROBE,
	output logic                           HIGH_BYTE_STROBE,
	output logic                           MEMORY_DISABLE,
	output logic                           READY,
	output logic      [fpc_pkg::ADDR_W-1:0] DISPLAY,
	output logic                           WAIT_LAMP,
	output logic                           RUN_LAMP,
	output logic                           HALT_LAMP,
	output logic                           INTERRUPT_LAMP,
	output logic      [3:0]                CYCLE_LAMPS
);
	import fpc_pkg::*;

	fpc_load_if    ld ();          // Link to the address load sequencer
	fpc_ex_state_t ex_reg;         // Examine sequencer state
	fpc_ex_state_t ex_next;
	logic          ex_phase2_reg;  // Second phase of the two-phase selector
	logic          ex_phase2_next;
	logic [ADDR_W-1:0] count_reg;  // Panel address counter
	logic [ADDR_W-1:0] count_next;
	logic [ADDR_W-1:0] disp_reg;   // Display latch
	logic [ADDR_W-1:0] disp_next;
	logic [DATA_W-1:0] data_reg;   // Last byte read back
	logic          exam_d_reg;     // Previous examine level for edge detection
	logic          load_d_reg;     // Previous load level
	logic          start_d_reg;    // Previous start level
	logic          resume_d_reg;   // Previous resume level
	logic [1:0]    ts_d_reg;       // Previous decoded time state
	logic          resume_ff_reg;  // Continue flip-flop
	logic          read_reg;       // Forced read and gate drive
	logic          ld_start_reg;   // Load request to sequencer
	logic          ld_start_next;
	logic [DATA_W-1:0] out_reg;    // Output data bus register
	logic          oe_reg;
	logic          strb_lo_reg;
	logic          strb_hi_reg;
	logic          start_ff;       // From run control
	logic          halt_ff;
	logic          inject;
	logic [DATA_W-1:0] inject_byte;
	logic          mem_block;
	logic          inject_reg;
	logic          block_reg;
	logic          run_lamp_reg;
	logic          halt_lamp_reg;
	logic          int_lamp_reg;
	logic          force_int_reg;  // Interrupt request line to the processor
	logic          wait_lamp_reg;
	logic [3:0]    cycle_reg;

	// Edge detectors on operator switches; inputs are clean, synchronous levels
	wire exam_press   = EXAMINE_SWITCH && !exam_d_reg;
	wire load_press   = LOAD_SWITCH && !load_d_reg;
	wire start_press  = RUN_FROM_ADDRESS_SWITCH && !start_d_reg;
	wire resume_press = RESUME_SWITCH && !resume_d_reg;
	// Third time state entry, the internal pulse that ends a step
	wire third_state_pulse = (TIME_STATE == TS_THIRD) && (ts_d_reg != TS_THIRD);
	// Panel address functions are honoured only while the stop switch is set
	wire halted_ok = STOP_SWITCH;

	// Address load sequencer
	fpc_load_seq #(
		.HOLD_CYC (HOLD_CYC)
	) u_load (
		.clk (SYS_CLK),
		.rst (SYS_RST),
		.ld  (ld.seq)
	);

	// Start and halt jamming control
	fpc_run_ctl #(
		.JUMP_OPCODE (JUMP_OPCODE),
		.HALT_OPCODE (HALT_OPCODE)
	) u_run (
		.clk         (SYS_CLK),
		.rst         (SYS_RST),
		.start_press (start_press),
		.stop_level  (STOP_SWITCH),
		.ack_flag    (INTERRUPT_ACK_STATE_FLAG),
		.third_pulse (third_state_pulse),
		.halt_exec   (HALT_EXECUTED),
		.addr        (SWITCH_REG),
		.start_ff    (start_ff),
		.halt_ff     (halt_ff),
		.inject      (inject),
		.inject_byte (inject_byte),
		.mem_block   (mem_block)
	);
	assign ld.start = ld_start_reg;

	// Examine sequencer and address counter next values
	always_comb begin
		ex_next        = ex_reg;
		ex_phase2_next = ex_phase2_reg;
		count_next     = count_reg;
		ld_start_next  = 1'b0;
		unique case (ex_reg)
			EX_IDLE: begin
				if (load_press && halted_ok && !ld.busy) begin
					count_next     = SWITCH_REG;
					ld_start_next  = 1'b1;
					ex_phase2_next = 1'b0;
					ex_next        = EX_HOLD;
				end else if (exam_press && halted_ok && !ld.busy) begin
					if (ex_phase2_reg) begin
						count_next    = count_reg + 14'h0001;
						ld_start_next = 1'b1;
						ex_next       = EX_HOLD;
					end else begin
						ex_next = EX_READ;
					end
					ex_phase2_next = 1'b1;
				end
			end
			EX_HOLD: begin
				// Wait out the load and its hold-off; a plain load reads nothing
				if (ld.done) begin
					ex_next = ex_phase2_reg ? EX_READ : EX_IDLE;
				end
			end
			EX_READ: begin
				ex_next = EX_PH1;
			end
			EX_PH1: begin
				ex_next = EX_PH2;
			end
			EX_PH2: begin
				ex_next = EX_IDLE;
			end
			default: begin
				ex_next = EX_IDLE;
			end
		endcase
	end

	// Display source: address, captured data, or the waiting cycle's address while stepping
	always_comb begin
		disp_next = disp_reg;
		if (SHOW_ADDRESS_BUTTON) begin
			disp_next = PROC_ADDR;
		end else if (SHOW_DATA_BUTTON) begin
			disp_next = {6'h00, data_reg};
		end else if (ex_reg == EX_PH2) begin
			disp_next = {6'h00, DATA_IN};
		end else if (WAITING && !halted_ok) begin
			disp_next = PROC_ADDR;
		end
	end

	// Examine state, counter and edge history
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ex_reg        <= EX_IDLE;
			ex_phase2_reg <= 1'b0;
			count_reg     <= 14'h0000;
			ld_start_reg  <= 1'b0;
			exam_d_reg    <= 1'b0;
			load_d_reg    <= 1'b0;
			start_d_reg   <= 1'b0;
			resume_d_reg  <= 1'b0;
			ts_d_reg      <= 2'h0;
		end else begin
			ex_reg        <= ex_next;
			ex_phase2_reg <= ex_phase2_next;
			count_reg     <= count_next;
			ld_start_reg  <= ld_start_next;
			exam_d_reg    <= EXAMINE_SWITCH;
			load_d_reg    <= LOAD_SWITCH;
			start_d_reg   <= RUN_FROM_ADDRESS_SWITCH;
			resume_d_reg  <= RESUME_SWITCH;
			ts_d_reg      <= TIME_STATE;
		end
	end

	// Forced read and gate are one level so they always rise together
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			read_reg <= 1'b0;
			data_reg <= 8'h00;
			disp_reg <= 14'h0000;
		end else begin
			read_reg <= (ex_next == EX_READ) || (ex_next == EX_PH1) || (ex_next == EX_PH2);
			if (ex_reg == EX_PH2) begin
				data_reg <= DATA_IN;
			end
			disp_reg <= disp_next;
		end
	end

	// Continue flip-flop: a resume press in step mode sets it, third state entry clears it
	// Set wins so a press landing on the third state is not lost
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			resume_ff_reg <= 1'b0;
		end else if (resume_press && STEP_MODE_SWITCH) begin
			resume_ff_reg <= 1'b1;
		end else if (third_state_pulse) begin
			resume_ff_reg <= 1'b0;
		end
	end

	// Output data bus: jam bytes take priority over address load bytes
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			out_reg     <= 8'h00;
			oe_reg      <= 1'b0;
			strb_lo_reg <= 1'b0;
			strb_hi_reg <= 1'b0;
			inject_reg  <= 1'b0;
			block_reg   <= 1'b0;
		end else begin
			if (inject) begin
				out_reg <= inject_byte;
			end else if (ld.sel_high) begin
				out_reg <= {2'b11, count_reg[13:8]};
			end else begin
				out_reg <= count_reg[7:0];
			end
			oe_reg      <= inject || ld.busy;
			strb_lo_reg <= ld.low_strb;
			strb_hi_reg <= ld.high_strb;
			inject_reg  <= inject;
			block_reg   <= mem_block;
		end
	end

	// Indicator lamps
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			run_lamp_reg  <= 1'b0;
			halt_lamp_reg <= 1'b0;
			int_lamp_reg  <= 1'b0;
			wait_lamp_reg <= 1'b0;
			cycle_reg     <= 4'h0;
		end else begin
			if (HALT_EXECUTED) begin
				run_lamp_reg  <= 1'b0;
				halt_lamp_reg <= 1'b1;
			end else if (start_press && !STOP_SWITCH) begin
				run_lamp_reg  <= 1'b1;
				halt_lamp_reg <= 1'b0;
			end
			int_lamp_reg  <= halt_ff;
			wait_lamp_reg <= WAITING && STEP_MODE_SWITCH;
			if (WAITING) begin
				cycle_reg <= {FETCH_CYCLE_TYPE, COMMAND_CYCLE_TYPE,
				              READ_CYCLE_TYPE, WRITE_CYCLE_TYPE};
			end
		end
	end

	// Ready is low in step mode unless the continue flip-flop is set
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			READY <= 1'b1;
		end else begin
			READY <= !STEP_MODE_SWITCH || resume_ff_reg;
		end
	end

	assign DATA_OUT             = out_reg;
	assign DATA_OE              = oe_reg;
	assign FORCED_MEMORY_READ   = read_reg;
	assign FORCED_INPUT_GATE    = read_reg;
	assign FORCED_INTERRUPT     = force_int_reg;
	assign OPCODE_INJECT_ENABLE = inject_reg;
	assign LOW_BYTE_STROBE      = strb_lo_reg;
	assign HIGH_BYTE_STROBE     = strb_hi_reg;
	assign MEMORY_DISABLE       = block_reg;
	assign DISPLAY              = disp_reg;
	assign WAIT_LAMP            = wait_lamp_reg;
	assign RUN_LAMP             = run_lamp_reg;
	assign HALT_LAMP            = halt_lamp_reg;
	assign INTERRUPT_LAMP       = int_lamp_reg;
	assign CYCLE_LAMPS          = cycle_reg;

	// Interrupt line from a flop: a halt request, or a start until jamming begins
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			force_int_reg <= 1'b0;
		end else begin
			force_int_reg <= halt_ff || (start_ff && !inject);
		end
	end
endmodule : fpc_front_panel
`default_nettype wire

// file: fpc_front_panel_chk.sv
// Port timing checker for the front panel top, attached by bind
`timescale 1ns/1ps
`default_nettype none
module fpc_front_panel_chk
	import fpc_pkg::*;
#(
	parameter int HOLD_CYC = LOAD_HOLD_CYC
) (
	input wire logic       SYS_CLK,
	input wire logic       SYS_RST,
	input wire logic       RESUME_SWITCH,
	input wire logic       RUN_FROM_ADDRESS_SWITCH,
	input wire logic       STOP_SWITCH,
	input wire logic       STEP_MODE_SWITCH,
	input wire logic [1:0] TIME_STATE,
	input wire logic       HALT_EXECUTED,
	input wire logic       WAITING,
	input wire logic       FORCED_MEMORY_READ,
	input wire logic       FORCED_INPUT_GATE,
	input wire logic       FORCED_INTERRUPT,
	input wire logic       OPCODE_INJECT_ENABLE,
	input wire logic       LOW_BYTE_STROBE,
	input wire logic       HIGH_BYTE_STROBE,
	input wire logic       MEMORY_DISABLE,
	input wire logic       READY,
	input wire logic       RUN_LAMP,
	input wire logic       HALT_LAMP,
	input wire logic       INTERRUPT_LAMP
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);
	// Forced read stands three clocks, then drops
	sequence s_read3;
		FORCED_MEMORY_READ [*3] ##1 !FORCED_MEMORY_READ;
	endsequence
	// High byte strobe follows the low one closely
	sequence s_high_soon;
		##[1:3] HIGH_BYTE_STROBE;
	endsequence
	property p_gate_pair;
		FORCED_MEMORY_READ == FORCED_INPUT_GATE;
	endproperty
	property p_read_len;
		$rose(FORCED_MEMORY_READ) |-> s_read3;
	endproperty
	property p_strobes;
		LOW_BYTE_STROBE |-> s_high_soon;
	endproperty
	property p_ready_set;
		$rose(RESUME_SWITCH) && STEP_MODE_SWITCH && WAITING |-> ##[1:3] READY;
	endproperty
	property p_ready_clr;
		STEP_MODE_SWITCH && TIME_STATE == TS_THIRD && !RESUME_SWITCH |-> ##[1:3] !READY;
	endproperty
	property p_stop_int;
		$rose(STOP_SWITCH) |-> ##[1:3] (FORCED_INTERRUPT && INTERRUPT_LAMP);
	endproperty
	property p_start_run;
		$rose(RUN_FROM_ADDRESS_SWITCH) && !STOP_SWITCH && HALT_LAMP
			|-> ##[1:3] (FORCED_INTERRUPT && RUN_LAMP);
	endproperty
	property p_halt_lamps;
		$rose(HALT_EXECUTED) |-> ##[1:2] (HALT_LAMP && !RUN_LAMP);
	endproperty
	property p_jam_mem;
		OPCODE_INJECT_ENABLE && !STOP_SWITCH |-> MEMORY_DISABLE;
	endproperty
	a_gate_pair: assert property (p_gate_pair) else $error("read and gate differ");
	a_read_len: assert property (p_read_len) else $error("forced read length");
	a_strobes: assert property (p_strobes) else $error("high strobe missing");
	a_ready_set: assert property (p_ready_set) else $error("ready not raised");
	a_ready_clr: assert property (p_ready_clr) else $error("ready not dropped");
	a_stop_int: assert property (p_stop_int) else $error("stop gave no interrupt");
	a_start_run: assert property (p_start_run) else $error("start gave no run");
	a_halt_lamps: assert property (p_halt_lamps) else $error("halt lamps wrong");
	a_jam_mem: assert property (p_jam_mem) else $error("memory enabled in jam");
endmodule : fpc_front_panel_chk
bind fpc_front_panel fpc_front_panel_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (.*);
`default_nettype wire

// file: fpc_proc_model.sv
// Behavioural processor board answering the panel
`timescale 1ns/1ps
`default_nettype none
module fpc_proc_model
	import fpc_pkg::*;
(
	input wire logic              SYS_CLK,
	input wire logic              SYS_RST,
	input wire logic              READY,
	input wire logic              FORCED_INTERRUPT,
	input wire logic              FORCED_MEMORY_READ,
	input wire logic              FORCED_INPUT_GATE,
	input wire logic              OPCODE_INJECT_ENABLE,
	input wire logic              LOW_BYTE_STROBE,
	input wire logic              HIGH_BYTE_STROBE,
	input wire logic [DATA_W-1:0] DATA_OUT,
	input wire logic              DATA_OE,
	output logic [1:0]            TIME_STATE,
	output logic                  INTERRUPT_ACK_STATE_FLAG,
	output logic                  HALT_EXECUTED,
	output logic                  WAITING,
	output logic                  FETCH_CYCLE_TYPE,
	output logic                  COMMAND_CYCLE_TYPE,
	output logic                  READ_CYCLE_TYPE,
	output logic                  WRITE_CYCLE_TYPE,
	output logic [ADDR_W-1:0]     PROC_ADDR,
	output logic [DATA_W-1:0]     DATA_IN
);
	logic [7:0] q[$];     // Bytes jammed by the panel
	logic [7:0] last_reg; // Last value on the data lines
	logic [1:0] sub_reg;  // Clock within a time state
	logic       halt_reg, pend_reg, irq_reg;
	int         mcyc;     // Finished machine cycles
	wire  logic rd = FORCED_MEMORY_READ && FORCED_INPUT_GATE && !OPCODE_INJECT_ENABLE;
	// Released lines show the inverse of their last value, never a held copy
	assign DATA_IN = rd ? PROC_ADDR[7:0] ^ {PROC_ADDR[13:8], 2'h3} : ~last_reg;
	assign {FETCH_CYCLE_TYPE, COMMAND_CYCLE_TYPE, READ_CYCLE_TYPE, WRITE_CYCLE_TYPE} =
		4'h8 >> mcyc[1:0];
	// Each time state lasts four clocks, the second stretched while READY is low; halted means idle until interrupted
	always @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			{TIME_STATE, sub_reg, pend_reg, irq_reg, WAITING, PROC_ADDR} <= '0;
			{INTERRUPT_ACK_STATE_FLAG, HALT_EXECUTED, last_reg} <= '0;
			halt_reg <= 1'b1;
			mcyc <= 0;
		end else begin
			last_reg <= DATA_IN;
			irq_reg <= FORCED_INTERRUPT;
			INTERRUPT_ACK_STATE_FLAG <= 1'b0;
			HALT_EXECUTED <= 1'b0;
			if (FORCED_INTERRUPT && !irq_reg) pend_reg <= 1'b1;
			if (LOW_BYTE_STROBE) PROC_ADDR[7:0] <= DATA_OUT;
			if (HIGH_BYTE_STROBE) PROC_ADDR[13:8] <= DATA_OUT[5:0];
			if (TIME_STATE == 2'h0) begin
				if (pend_reg) TIME_STATE <= TS_FIRST;
			end else if (sub_reg != 2'h3) begin
				sub_reg <= sub_reg + 2'h1;
			end else if (TIME_STATE == TS_SECOND && !READY) begin
				WAITING <= 1'b1;
			end else begin
				sub_reg <= 2'h0;
				WAITING <= 1'b0;
				if (TIME_STATE == TS_FIRST) TIME_STATE <= TS_SECOND;
				else if (TIME_STATE == TS_SECOND) begin
					TIME_STATE <= TS_THIRD;
					INTERRUPT_ACK_STATE_FLAG <= pend_reg;
					pend_reg <= 1'b0;
				end else begin
					mcyc <= mcyc + 1;
					if (DATA_OE) q.push_back(DATA_OUT);
					if (DATA_OE && q.size() == 1 && DATA_OUT == HALT_OPCODE_DEF) begin
						halt_reg <= 1'b1;
						HALT_EXECUTED <= 1'b1;
						TIME_STATE <= 2'h0;
					end else if (DATA_OE && q.size() == 3) begin
						halt_reg <= 1'b0;
						PROC_ADDR <= {q[2][5:0], q[1]};
						TIME_STATE <= TS_FIRST;
					end else begin
						TIME_STATE <= (halt_reg && !DATA_OE) ? 2'h0 : TS_FIRST;
						if (!halt_reg) PROC_ADDR <= PROC_ADDR + 14'h1;
					end
				end
			end
		end
	end
endmodule : fpc_proc_model
`default_nettype wire

// file: test_front_panel_control.sv
// Self-checking bench for the front panel control block
`timescale 1ns/1ps
`default_nettype none
module test_front_panel_control;
	import fpc_pkg::*;
	localparam int HOLD_CYC = 25; // Full hold-off, 200 ns at 8 ns
	logic SYS_CLK, SYS_RST, SHOW_ADDRESS_BUTTON, STEP_MODE_SWITCH, STOP_SWITCH;
	logic EXAMINE_SWITCH, LOAD_SWITCH, RESUME_SWITCH, RUN_FROM_ADDRESS_SWITCH;
	logic [ADDR_W-1:0] SWITCH_REG, a;
	wire logic SHOW_DATA_BUTTON = 1'b0;
	wire logic [1:0] TIME_STATE;
	wire logic INTERRUPT_ACK_STATE_FLAG, HALT_EXECUTED, WAITING, DATA_OE, READY;
	wire logic FETCH_CYCLE_TYPE, COMMAND_CYCLE_TYPE, READ_CYCLE_TYPE, WRITE_CYCLE_TYPE;
	wire logic FORCED_MEMORY_READ, FORCED_INPUT_GATE, FORCED_INTERRUPT, OPCODE_INJECT_ENABLE;
	wire logic LOW_BYTE_STROBE, HIGH_BYTE_STROBE, MEMORY_DISABLE, WAIT_LAMP, RUN_LAMP;
	wire logic HALT_LAMP, INTERRUPT_LAMP;
	wire logic [ADDR_W-1:0] PROC_ADDR, DISPLAY;
	wire logic [DATA_W-1:0] DATA_IN, DATA_OUT;
	wire logic [3:0] CYCLE_LAMPS;
	int n_errors = 0, num_checks = 0, seed = 52941, n, m;
	fpc_front_panel #(.HOLD_CYC(HOLD_CYC)) DUT (.*);
	fpc_proc_model board (.*);
	// Free-running system clock
	initial begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	// Byte the model memory holds at an address
	function automatic logic [7:0] mem(input logic [ADDR_W-1:0] x);
		return x[7:0] ^ {x[13:8], 2'h3};
	endfunction : mem
	task automatic chk(input string s, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wt(input int k);
		repeat (k) @(posedge SYS_CLK);
	endtask : wt
	// Load, resume or run switch held three clocks, then time to settle
	task automatic press(input int k);
		@(posedge SYS_CLK);
		{RUN_FROM_ADDRESS_SWITCH, RESUME_SWITCH, LOAD_SWITCH} <= 3'h1 << k;
		wt(3);
		{RUN_FROM_ADDRESS_SWITCH, RESUME_SWITCH, LOAD_SWITCH} <= 3'h0;
		wt(60);
	endtask : press
	// Examine held until the forced read shows; n counts the clocks
	task automatic exam();
		@(posedge SYS_CLK);
		EXAMINE_SWITCH <= 1'b1;
		n = 0;
		do begin
			@(negedge SYS_CLK);
			n++;
		end while (FORCED_MEMORY_READ !== 1'b1 && n < 100);
		@(posedge SYS_CLK);
		EXAMINE_SWITCH <= 1'b0;
		wt(8);
	endtask : exam
	task automatic end_of_test();
		if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// Main sequence: halt, examine runs, start, single stepping
	initial begin
		SYS_RST = 1'b1;
		{SHOW_ADDRESS_BUTTON, STEP_MODE_SWITCH, STOP_SWITCH, EXAMINE_SWITCH} = '0;
		{LOAD_SWITCH, RESUME_SWITCH, RUN_FROM_ADDRESS_SWITCH} = '0;
		SWITCH_REG = '0;
		wt(20);
		SYS_RST <= 1'b0;
		wt(2);
		chk("ready", 1, READY);
		STOP_SWITCH <= 1'b1;
		wt(60);
		chk("halt op", HALT_OPCODE_DEF, board.q[0]);
		chk("halt lamp", 1, HALT_LAMP);
		chk("run lamp", 0, RUN_LAMP);
		repeat (2) begin
			a = ADDR_W'($random(seed));
			SWITCH_REG <= a;
			press(0);
			chk("loaded", a, PROC_ADDR);
			for (int k = 0; k < 4; k++) begin
				exam();
				chk("holdoff", 1, ((k > 0) == (n >= HOLD_CYC)) && n < 100);
				chk("addr", ADDR_W'(a + k), PROC_ADDR);
				chk("data", mem(ADDR_W'(a + k)), DISPLAY[7:0]);
			end
			SHOW_ADDRESS_BUTTON <= 1'b1;
			wt(3);
			chk("show", ADDR_W'(a + 3), DISPLAY);
			SHOW_ADDRESS_BUTTON <= 1'b0;
		end
		STOP_SWITCH <= 1'b0;
		a = ADDR_W'($random(seed));
		SWITCH_REG <= a;
		board.q.delete();
		wt(4);
		press(2);
		wt(40);
		chk("jam size", 3, ADDR_W'(board.q.size()));
		chk("jump", JUMP_OPCODE_DEF, board.q[0]);
		chk("low", a[7:0], board.q[1]);
		chk("high", {2'h3, a[13:8]}, board.q[2]);
		chk("run lamp", 1, RUN_LAMP);
		STEP_MODE_SWITCH <= 1'b1;
		wt(40);
		repeat (3) begin
			m = board.mcyc;
			chk("ready low", 0, READY);
			chk("wait lamp", 1, WAIT_LAMP);
			chk("cycle lamps", 4'h8 >> (m % 4), CYCLE_LAMPS);
			chk("step addr", PROC_ADDR, DISPLAY);
			press(1);
			chk("one cycle", ADDR_W'(m + 1), ADDR_W'(board.mcyc));
		end
		end_of_test();
	end
	// Watchdog far beyond the fewer than a thousand clocks the sequence takes
	initial begin
		wt(20000);
		n_errors++;
		end_of_test();
	end
endmodule : test_front_panel_control
`default_nettype wire
